// >>> design/periph_reg_transfer_decode.sv
// How it works
// RULE1: Comparator mode: partner register to upper nibble
// RULE2: Comparator mode: accumulator to lower nibble too
// RULE3: Conversion mode: comparator load is no-operation
// RULE4: Interrupt control read loads accumulator
// RULE5: Serial control read loads accumulator
// RULE6: Wakeup control read loads accumulator
// RULE7: One word, one cycle, no carry/skip
`timescale 1ns/10ps
`default_nettype none
`include "periph_xfer_regs.svh"
module periph_reg_transfer_decode
  import periph_xfer_pkg::*;
#(
  // Datapath widths; the logic serves only these
  parameter int unsigned NIBBLE_W = 4,
  parameter int unsigned OPCODE_W = 10,
  parameter int unsigned COMP_W   = 8
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Instruction stream
  input  wire instr_word_s  instr,
  // Core registers
  input  wire nibble_t      acc_in,
  input  wire nibble_t      partner_in,
  input  wire logic         converter_mode_bit,
  // Peripheral control registers
  input  wire periph_ctrl_s periph_ctrl,
  // Results
  output logic              acc_write,
  output nibble_t           acc_value,
  output logic [7:0]        comparator_reg,
  output logic              instr_done,
  output logic              carry_write,
  output logic              skip_next
);

  // Package types fix the widths, so other values are refused
  generate
    if (NIBBLE_W != $bits(nibble_t)) begin : g_bad_nibble
      $error("NIBBLE_W must equal the nibble type width");
    end
  endgenerate

  generate
    if (OPCODE_W != $bits(opcode_t)) begin : g_bad_opcode
      $error("OPCODE_W must equal the opcode type width");
    end
  endgenerate

  generate
    if (COMP_W != 2 * NIBBLE_W) begin : g_bad_comp
      $error("COMP_W must hold exactly two nibbles");
    end
  endgenerate

  generate
    if (COMP_W != 8) begin : g_bad_comp_port
      $error("COMP_W must match the comparator port width");
    end
  endgenerate

  // Opcode match lines
  logic       code_is_comp_load;
  logic       code_is_irq_read;
  logic       code_is_serial_read;
  logic       code_is_wakeup_read;
  logic       mode_is_comparator;

  // Decoded operation and next values
  xfer_op_e   op;
  logic [7:0] next_comparator_reg;
  logic       next_acc_write;
  nibble_t    next_acc_value;
  logic       next_instr_done;

  // Full 10-bit match; any other code is left to the rest of the core
  assign code_is_comp_load   = (instr.code == `OPC_COMPARATOR_LOAD);
  assign code_is_irq_read    = (instr.code == `OPC_IRQ_CTRL_READ);
  assign code_is_serial_read = (instr.code == `OPC_SERIAL_CTRL_READ);
  assign code_is_wakeup_read = (instr.code == `OPC_WAKEUP_CTRL_READ);
  assign mode_is_comparator  = converter_mode_bit;

  always_comb begin
    if (!instr.valid) begin
      op = op_none;
    end else if (code_is_comp_load) begin
      op = op_comp_load;
    end else if (code_is_irq_read) begin
      op = op_irq_read;
    end else if (code_is_serial_read) begin
      op = op_serial_read;
    end else if (code_is_wakeup_read) begin
      op = op_wakeup_read;
    end else begin
      op = op_none;
    end
  end

  // Comparator next value; conversion mode keeps it untouched
  always_comb begin
    next_comparator_reg = comparator_reg;
    case (op)
      op_comp_load: begin
        if (mode_is_comparator) begin
          next_comparator_reg[7:4] = partner_in; // RULE1
          next_comparator_reg[3:0] = acc_in; // RULE2
        end else begin
          next_comparator_reg = comparator_reg; // RULE3
        end
      end
      default: begin
        next_comparator_reg = comparator_reg;
      end
    endcase
  end

  // Accumulator next value; value holds so the core may read it late
  always_comb begin
    next_acc_write = 1'h0;
    next_acc_value = acc_value;
    case (op)
      op_irq_read: begin
        next_acc_write = 1'h1;
        next_acc_value = periph_ctrl.irq_ctrl_reg_first; // RULE4
      end
      op_serial_read: begin
        next_acc_write = 1'h1;
        next_acc_value = periph_ctrl.serial_ctrl_reg_first; // RULE5
      end
      op_wakeup_read: begin
        next_acc_write = 1'h1;
        next_acc_value = periph_ctrl.wakeup_ctrl_reg_first; // RULE6
      end
      default: begin
        next_acc_write = 1'h0;
        next_acc_value = acc_value;
      end
    endcase
  end

  // Every one of these finishes in a single cycle
  always_comb begin
    case (op)
      op_comp_load,
      op_irq_read,
      op_serial_read,
      op_wakeup_read: begin
        next_instr_done = 1'h1; // RULE7
      end
      default: begin
        next_instr_done = 1'h0;
      end
    endcase
  end

  // Comparator register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      comparator_reg <= `COMPARATOR_RESET;
    end else begin
      comparator_reg <= next_comparator_reg;
    end
  end

  // Accumulator write strobe, one cycle per read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_write <= 1'h0;
    end else begin
      acc_write <= next_acc_write;
    end
  end

  // Accumulator value, registered so the write lands one edge later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_value <= `NIBBLE_RESET;
    end else begin
      acc_value <= next_acc_value;
    end
  end

  // Completion pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      instr_done <= 1'h0;
    end else begin
      instr_done <= next_instr_done;
    end
  end

  // Carry and skip never touched by these instructions
  assign carry_write = 1'h0; // RULE7
  assign skip_next   = 1'h0; // RULE7

endmodule // periph_reg_transfer_decode
`default_nettype wire

// >>> design/periph_xfer_regs.svh
`ifndef PERIPH_XFER_REGS_SVH
`define PERIPH_XFER_REGS_SVH
`define OPC_COMPARATOR_LOAD  10'h239
`define OPC_IRQ_CTRL_READ    10'h257
`define OPC_SERIAL_CTRL_READ 10'h242
`define OPC_WAKEUP_CTRL_READ 10'h256
`define NIBBLE_RESET         4'h0
`define COMPARATOR_RESET     8'h00
`endif

// >>> design/periph_xfer_pkg.sv
package periph_xfer_pkg;
  typedef logic [3:0] nibble_t;
  typedef logic [9:0] opcode_t;
  typedef struct packed {
    logic    valid;
    opcode_t code;
  } instr_word_s;
  typedef struct packed {
    nibble_t irq_ctrl_reg_first;
    nibble_t serial_ctrl_reg_first;
    nibble_t wakeup_ctrl_reg_first;
  } periph_ctrl_s;
  typedef enum logic [4:0] {
    op_none        = 5'h01,
    op_comp_load   = 5'h02,
    op_irq_read    = 5'h04,
    op_serial_read = 5'h08,
    op_wakeup_read = 5'h10
  } xfer_op_e;
endpackage

// >>> tb/xchk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module xchk import periph_xfer_pkg::*; (
  input wire logic clock, reset_n, converter_mode_bit, acc_write, instr_done, carry_write, skip_next,
  input wire instr_word_s instr,
  input wire nibble_t acc_in, partner_in, acc_value,
  input wire periph_ctrl_s periph_ctrl,
  input wire logic [7:0] comparator_reg);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire m = converter_mode_bit, ld = instr == 11'h639, ir = instr == 11'h657;
  wire sr = instr == 11'h642, wk = instr == 11'h656, rd = ir || sr || wk;
  wire [3:0] rv = ir ? periph_ctrl[11:8] : sr ? periph_ctrl[7:4] : periph_ctrl[3:0];
  wire [7:0] ba = {partner_in, acc_in};
  chk_comp_load: assert property (ld && m |=> comparator_reg == $past(ba)) else $error("ld");
  chk_load_nop: assert property (ld && !m |=> $stable(comparator_reg) && !acc_write) else $error("nop");
  chk_ctrl_read: assert property (rd |=> acc_write && acc_value == $past(rv)) else $error("rd");
  chk_one_cycle: assert property (ld || rd |=> instr_done && !carry_write && !skip_next) else $error("d");
  chk_nop_done: assert property (ld && !m |=> instr_done) else $error("nop done");
  chk_idle_quiet: assert property (!ld && !rd |=> !acc_write && !instr_done) else $error("idle");
  chk_no_side: assert property (!carry_write && !skip_next) else $error("side");
  cover property (ld && m);
  cover property (ld && !m);
  cover property (ir ##2 sr);
endmodule // xchk
bind periph_reg_transfer_decode xchk u_chk (.*);
`default_nettype wire

// >>> tb/periph_reg_transfer_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
module periph_reg_transfer_decode_tb;
  import periph_xfer_pkg::*;
  logic clock = 0, reset_n = 0, converter_mode_bit = 1, acc_write, instr_done, carry_write, skip_next;
  instr_word_s instr = 0;
  nibble_t acc_in = 4'h6, partner_in = 4'h9, acc_value;
  periph_ctrl_s periph_ctrl = 12'ha5c;
  logic [7:0] comparator_reg;
  int bad_count = 0, check_count = 0;
  periph_reg_transfer_decode DUT (.*);
  initial forever #2 clock = ~clock;
  task chk(string n, logic [15:0] s, e);
    check_count++;
    if (s !== e) begin bad_count++; $display("FAIL %s exp %h got %h", n, e, s); end
  endtask
  task issue(opcode_t c);
    @(negedge clock) instr = {1'b1, c};
    @(negedge clock) instr.valid = 0;
  endtask
  task t_read(opcode_t c, nibble_t e);
    issue(c);
    chk("rd", {instr_done, acc_write, carry_write, skip_next, acc_value}, {4'hc, e});
  endtask
  task t_load;
    issue(10'h239);
    chk("ld", {instr_done, acc_write, comparator_reg}, 16'h296);
    converter_mode_bit = 0;
    acc_in = 4'h1;
    issue(10'h239);
    chk("nop", {instr_done, acc_write, comparator_reg}, 16'h296);
  endtask
  task t_b2b;
    @(negedge clock) instr = {1'h1, 10'h242};
    @(negedge clock) instr = {1'h1, 10'h256};
    chk("b2b1", {acc_write, acc_value}, {1'h1, 4'h5});
    @(negedge clock) instr.valid = 0;
    chk("b2b2", {acc_write, acc_value}, {1'h1, 4'hc});
    @(negedge clock);
    chk("drop", {instr_done, acc_write, acc_value}, {2'h0, 4'hc});
  endtask
  task t_midreset;
    @(negedge clock) reset_n = 0;
    @(negedge clock);
    chk("rst", {instr_done, acc_write, carry_write, skip_next, acc_value, comparator_reg}, 16'h0);
    reset_n = 1;
  endtask
  task t_other;
    issue(10'h258);
    chk("oth", {instr_done, acc_write, comparator_reg}, 16'h096);
  endtask
  task report_and_stop;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1;
    t_read(10'h257, 4'ha);
    t_read(10'h242, 4'h5);
    t_read(10'h256, 4'hc);
    t_b2b;
    t_midreset;
    t_read(10'h257, 4'ha);
    t_load;
    t_other;
    report_and_stop;
  end
endmodule // periph_reg_transfer_decode_tb
`default_nettype wire
